// file: design/fscl_ctrl.sv
// flight computer side sequencer that drives the stage sequence decoders
// Notes on behaviour
// R1 - decoder drives at most one of 112 channels from latched code
// R2 - controller starts commands no closer than one per 100 ms
// R3 - select, read and reset each go out on a redundant pair
// R4 - code, verify, read, reset shared; each decoder has own select line
// R5 - decoder picks same channel for true code or its complement
// R6 - register bits 1-8 hold command, bits 9-13 decoder selection
// R7 - bit 14 forces reset of all decoders, bit 15 strobes read
// R8 - register written in two passes: bits 1-13, then bit 14 or 15
// R9 - latched decoder returns complement of code on eight verify lines
// R10 - match gives read strobe; mismatch gives reset and complemented resend
// R11 - verify lines must all be low before cycle; else reset, recheck
// R12 - select asserted with command bits; decoder latches only while selected
// R13 - after forced reset send complement with select, read without checking
// R14 - read strobe fires channel and triggers decoder automatic reset
// R15 - decoder has three telemetry outputs; register outputs observable too
// R16 - never select more than two decoders at once
// R17 - decoder ignores read strobe unless select was received
// R18 - decoder resets latched command and select at power up
// R19 - automatic reset acts after strobe removal, clears command and select
// R20 - codes mapping to no channel give no output when read
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fscl_ctrl
    import fscl_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = fscl_pkg::CMD_INTERVAL_CYC,
    parameter int unsigned STAGES       = fscl_pkg::NUM_STAGES
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_sys_rst,
    // software port
    input  wire logic [fscl_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [fscl_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [fscl_pkg::DATA_W-1:0]  o_rdata,
    // decoder lines
    output logic      [fscl_pkg::CODE_W-1:0]  o_cmd_code,
    output logic      [STAGES-1:0]            o_stage_sel_a,
    output logic      [STAGES-1:0]            o_stage_sel_b,
    output logic                              o_read_a,
    output logic                              o_read_b,
    output logic                              o_freset_a,
    output logic                              o_freset_b,
    input  wire logic [fscl_pkg::CODE_W-1:0]  i_verify
);
    import fscl_pkg::*;

    fscl_state_e          state_r;
    fscl_state_e          state_nxt;
    logic [CODE_W-1:0]    cmd_r;
    logic [STAGE_W-1:0]   stage_r;
    logic [CODE_W-1:0]    cur_code_r;
    logic                 pending_r;
    logic                 last_ok_r;
    logic                 last_retry_r;
    logic                 dropped_r;
    logic                 bad_stage_r;
    logic [CNT_W-1:0]     done_cnt_r;
    logic [SEQ_W-1:0]     seq_r;
    logic [SEQ_W-1:0]     seq_nxt;
    logic                 step_done;
    logic                 ivl_done;
    logic                 step_load;
    logic                 ivl_load;
    logic                 verify_ok;
    logic                 wr_cmd;
    logic                 stage_valid;
    logic [STAGES-1:0]    sel_vec;
    logic                 sel_on;

    assign wr_cmd      = i_wr && (i_addr == REG_CMD);
    assign stage_valid = i_wdata[STAGE_LSB +: STAGE_W] < STAGE_W'(STAGES);
    assign verify_ok   = (i_verify == ~cur_code_r);
    assign step_load   = (state_nxt != state_r);
    assign ivl_load    = state_r[0] && !state_nxt[0];
    assign sel_on      = state_nxt inside {FS_LOAD, FS_LOADC, FS_READ}; // [R12]

    fscl_timer #(
        .W (TMR_W)
    ) u_step_tmr (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (step_load),
        .i_value   (TMR_W'(STEP_CYC - 1)),
        .o_done    (step_done)
    );

    // spacing between successive command cycles
    fscl_timer #(
        .W (TMR_W)
    ) u_ivl_tmr (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (ivl_load),
        .i_value   (TMR_W'(INTERVAL_CYC - 1)),
        .o_done    (ivl_done)
    );

    // sequencing of one command cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FS_IDLE: begin
                if (pending_r && ivl_done) begin // [R2]
                    state_nxt = FS_CHECK;
                end
            end
            FS_CHECK: begin
                state_nxt = !step_done ? state_r : |i_verify ? FS_PRERST : FS_LOAD; // [R11]
            end
            FS_PRERST: begin
                state_nxt = step_done ? FS_CHECK : state_r; // [R11]
            end
            FS_LOAD: begin
                state_nxt = !step_done ? state_r : verify_ok ? FS_READ : FS_FRST; // [R10]
            end
            FS_FRST: begin
                state_nxt = step_done ? FS_LOADC : state_r; // [R13]
            end
            FS_LOADC: begin
                state_nxt = step_done ? FS_READ : state_r; // [R13]
            end
            FS_READ: begin
                state_nxt = step_done ? FS_REL : state_r;
            end
            FS_REL: begin
                state_nxt = step_done ? FS_IDLE : state_r;
            end
            default: begin
                state_nxt = FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_r <= FS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // code presented on the shared lines
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cur_code_r <= '0;
        end else if (state_nxt == FS_LOAD && state_r != FS_LOAD) begin
            cur_code_r <= cmd_r;
        end else if (state_nxt == FS_LOADC && state_r != FS_LOADC) begin
            cur_code_r <= ~cmd_r; // [R10] [R13]
        end
    end

    // stage index to one dedicated select line, never more than one
    always_comb begin
        sel_vec = '0;
        for (int i = 0; i < STAGES; i++) begin
            if (stage_r == STAGE_W'(i)) begin
                sel_vec[i] = 1'b1; // [R4] [R16]
            end
        end
    end

    // register image: pass one bits 0..12, pass two bit 13 or 14
    always_comb begin
        seq_nxt = '0;
        unique case (state_nxt)
            FS_LOAD: begin
                seq_nxt[CODE_LSB +: CODE_W]   = cmd_r; // [R6] [R8] [R12]
                seq_nxt[STAGE_LSB +: STAGE_W] = stage_r;
            end
            FS_LOADC: begin
                seq_nxt[CODE_LSB +: CODE_W]   = ~cmd_r; // [R13]
                seq_nxt[STAGE_LSB +: STAGE_W] = stage_r;
            end
            FS_READ: begin
                seq_nxt                       = seq_r;
                seq_nxt[READ_BIT]             = 1'b1; // [R7] [R8] [R17]
            end
            FS_PRERST, FS_FRST: begin
                seq_nxt[FRESET_BIT]           = 1'b1; // [R7] [R8]
            end
            default: begin
                seq_nxt = '0; // [R14] [R19]
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            seq_r <= '0;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // drive the decoder lines, each strobe on both lines of its pair
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cmd_code    <= '0;
            o_stage_sel_a <= '0;
            o_stage_sel_b <= '0;
            o_read_a      <= 1'b0;
            o_read_b      <= 1'b0;
            o_freset_a    <= 1'b0;
            o_freset_b    <= 1'b0;
        end else begin
            o_cmd_code    <= seq_nxt[CODE_LSB +: CODE_W]; // [R12]
            o_stage_sel_a <= sel_on ? sel_vec : '0; // [R3] [R12]
            o_stage_sel_b <= sel_on ? sel_vec : '0; // [R3]
            o_read_a      <= seq_nxt[READ_BIT]; // [R3]
            o_read_b      <= seq_nxt[READ_BIT];
            o_freset_a    <= seq_nxt[FRESET_BIT]; // [R3]
            o_freset_b    <= seq_nxt[FRESET_BIT];
        end
    end

    // software order and outcome tracking
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cmd_r        <= '0;
            stage_r      <= '0;
            pending_r    <= 1'b0;
            dropped_r    <= 1'b0;
            bad_stage_r  <= 1'b0;
        end else begin
            if (wr_cmd && !pending_r && stage_valid) begin
                cmd_r     <= i_wdata[CODE_LSB +: CODE_W];
                stage_r   <= i_wdata[STAGE_LSB +: STAGE_W];
                pending_r <= 1'b1;
            end else if (state_r == FS_REL && state_nxt == FS_IDLE) begin
                pending_r <= 1'b0;
            end
            // set wins over a write-one clear
            if (wr_cmd && pending_r) begin
                dropped_r <= 1'b1;
            end else if (i_wr && i_addr == REG_STATUS && i_wdata[ST_DROPPED]) begin
                dropped_r <= 1'b0;
            end
            if (wr_cmd && !pending_r && !stage_valid) begin
                bad_stage_r <= 1'b1;
            end else if (i_wr && i_addr == REG_STATUS && i_wdata[ST_BAD_STAGE]) begin
                bad_stage_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            last_ok_r    <= 1'b0;
            last_retry_r <= 1'b0;
            done_cnt_r   <= '0;
        end else begin
            if (state_r == FS_LOAD && step_done) begin
                last_ok_r    <= verify_ok;
                last_retry_r <= !verify_ok;
            end
            if (state_r == FS_REL && state_nxt == FS_IDLE) begin
                done_cnt_r <= done_cnt_r + 1'b1;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk) begin
        o_rdata <= '0;
        if (!i_sys_rst && i_rd) begin
            unique case (i_addr)
                REG_CMD: begin
                    o_rdata[CODE_LSB +: CODE_W]   <= cmd_r;
                    o_rdata[STAGE_LSB +: STAGE_W] <= stage_r;
                end
                REG_STATUS: begin
                    o_rdata[ST_BUSY]                <= !state_r[0];
                    o_rdata[ST_PENDING]             <= pending_r;
                    o_rdata[ST_LAST_OK]             <= last_ok_r;
                    o_rdata[ST_LAST_RETRY]          <= last_retry_r;
                    o_rdata[ST_DROPPED]             <= dropped_r;
                    o_rdata[ST_BAD_STAGE]           <= bad_stage_r;
                    o_rdata[ST_STATE_LSB +: 9]      <= state_r;
                end
                REG_VERIFY: begin
                    o_rdata[CODE_W-1:0] <= i_verify; // [R9]
                end
                REG_COUNT: begin
                    o_rdata[CNT_W-1:0] <= done_cnt_r;
                end
                default: begin
                    o_rdata <= '0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: design/fscl_pkg.sv
// constants for the flight sequence command link controller
package fscl_pkg;
    // controller clock and timing figures
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned CMD_INTERVAL_MS  = 100;
    localparam int unsigned CMD_INTERVAL_CYC = CMD_INTERVAL_MS * CLK_MHZ * 1000;
    // relay settle time per phase of the cycle
    localparam int unsigned STEP_TIME_US     = 10;
    localparam int unsigned STEP_CYC         = STEP_TIME_US * CLK_MHZ;
    localparam int unsigned TMR_W            = 32;

    // sequence command register layout, bits 1..15 of the word map to 0..14 here
    localparam int unsigned SEQ_W            = 15;
    localparam int unsigned CODE_W           = 8;
    localparam int unsigned CODE_LSB         = 0;
    localparam int unsigned STAGE_W          = 5;
    localparam int unsigned STAGE_LSB        = 8;
    localparam int unsigned FRESET_BIT       = 13;
    localparam int unsigned READ_BIT         = 14;
    localparam int unsigned NUM_STAGES       = 4;

    // software port
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 32;
    localparam logic [ADDR_W-1:0] REG_CMD    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_VERIFY = 8'h08;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h0c;

    // status bit positions
    localparam int unsigned ST_BUSY          = 0;
    localparam int unsigned ST_PENDING       = 1;
    localparam int unsigned ST_LAST_OK       = 2;
    localparam int unsigned ST_LAST_RETRY    = 3;
    localparam int unsigned ST_DROPPED       = 4;
    localparam int unsigned ST_BAD_STAGE     = 5;
    localparam int unsigned ST_STATE_LSB     = 8;

    localparam int unsigned CNT_W            = 16;

    typedef enum logic [8:0] {
        FS_IDLE   = 9'h001,
        FS_CHECK  = 9'h002,
        FS_PRERST = 9'h004,
        FS_LOAD   = 9'h008,
        FS_FRST   = 9'h010,
        FS_LOADC  = 9'h020,
        FS_READ   = 9'h040,
        FS_REL    = 9'h080,
        FS_SPARE  = 9'h100
    } fscl_state_e;
endpackage

// file: design/fscl_timer.sv
// down counter that reports when a loaded interval has run out
`timescale 1ns/1ps
`default_nettype none
module fscl_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic              o_done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_value;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // done depends on the count only, so a caller may load on done
    assign o_done = (cnt_r == '0);
endmodule
`default_nettype wire

// file: tb/flight_sequence_command_link_tb.sv
// self-checking bench for the sequence command link controller
`timescale 1ns/1ps
`default_nettype none
module flight_sequence_command_link_tb;
    import fscl_pkg::*;
    localparam int IV = 12000;
    logic        i_sys_clk = 1'h0;
    logic        i_sys_rst = 1'h1;
    logic        i_wr = 1'h0;
    logic        i_rd = 1'h0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata, rv;
    wire  [31:0] ver_all;
    wire  [27:0] chan_all;
    wire  [11:0] telem;
    logic [7:0]  code, ver;
    logic [3:0]  sel_a, sel_b;
    wire  [3:0]  fire;
    logic [3:0]  stuck = 4'h0;
    logic [3:0]  bad = 4'h0;
    logic        rd_a, rd_b, fr_a, fr_b;
    int          failures = 0;
    int          compares = 0;
    int          cyc = 0;
    int          last = -1;
    int          armed = 0;
    int          st;
    int          q[$];
    always #2 i_sys_clk = ~i_sys_clk;
    assign ver = ver_all[7:0] | ver_all[15:8] | ver_all[23:16] | ver_all[31:24];
    fscl_ctrl #(.INTERVAL_CYC(IV), .STAGES(4)) dut_u (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cmd_code(code),
        .o_stage_sel_a(sel_a), .o_stage_sel_b(sel_b), .o_read_a(rd_a), .o_read_b(rd_b),
        .o_freset_a(fr_a), .o_freset_b(fr_b), .i_verify(ver));
    fscl_dec_model dec_u[3:0] (
        .i_clk(i_sys_clk), .i_rst(i_sys_rst), .i_code(code), .i_sel_a(sel_a), .i_sel_b(sel_b),
        .i_rd_a(rd_a), .i_rd_b(rd_b), .i_fr_a(fr_a), .i_fr_b(fr_b), .i_stuck(stuck),
        .i_bad(bad), .o_verify(ver_all), .o_fire(fire), .o_chan(chan_all), .o_telem(telem));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_sys_clk);
        i_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_sys_clk);
        i_rd <= 1'h0;
        #1 rv = o_rdata;
    endtask
    // bench model: expected stage and channel per accepted command whose code maps to a channel
    task automatic issue(input int s, input logic [7:0] c);
        logic [7:0] t;
        t = c[7] ? ~c : c;
        if (t < 8'h70) q.push_back(s * 128 + t);
        armed = 1;
        wr(REG_CMD, {19'h0, 5'(s), c});
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(REG_STATUS);
            n++;
        end while (rv[ST_PENDING] !== 1'h0 && n < 20000);
        chk(rv[ST_PENDING], 1'h0, "completion");
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        // first activity of a cycle, load or pre-reset, one phase after its start
        if (armed != 0 && (|sel_a || fr_a)) begin
            if (last >= 0) chk(cyc - last >= IV, 1'h1, "spacing");
            last = cyc;
            armed = 0;
        end
        for (int i = 0; i < 4; i++) begin
            if (fire[i] === 1'h1) begin
                chk(q.size() > 0, 1'h1, "fire wanted");
                chk(telem[i*3+:3], 3'h7, "telemetry");
                if (q.size() > 0) chk(i * 128 + chan_all[i*7+:7], q.pop_front(), "channel");
            end
        end
    end
    initial begin
        void'($urandom(32'h5452));
        repeat (10) @(posedge i_sys_clk);
        i_sys_rst <= 1'h0;
        rd(REG_STATUS);
        chk(rv, 32'h100, "status reset");
        st = $urandom_range(3, 0);
        issue(st, 8'($urandom_range(111, 0)));
        wr(REG_CMD, 32'h0);
        rd(REG_STATUS);
        chk({rv[ST_DROPPED], rv[ST_PENDING]}, 2'h3, "refused");
        wr(REG_STATUS, 32'h10);
        wait_done();
        chk({rv[ST_DROPPED], rv[ST_LAST_OK]}, 2'h1, "match");
        for (int s = 4; s < 32; s += 27) begin
            wr(REG_CMD, {19'h0, 5'(s), 8'h01});
            rd(REG_STATUS);
            chk({rv[ST_BAD_STAGE], rv[ST_PENDING]}, 2'h2, "bad stage");
            wr(REG_STATUS, 32'h20);
        end
        // complement form right away, so the interval is exercised
        issue(st ^ 1, ~8'($urandom_range(111, 0)));
        wait_done();
        bad[st] <= 1'h1;
        issue(st, 8'($urandom_range(111, 0)));
        wait_done();
        chk(rv[ST_LAST_RETRY], 1'h1, "retry");
        bad <= 4'h0;
        // a decoder left latched must be cleared before loading
        stuck[st ^ 2] <= 1'h1;
        @(posedge i_sys_clk);
        stuck <= 4'h0;
        issue(st, 8'h6f);
        wait_done();
        issue(st, 8'h8f);
        wait_done();
        rd(8'h10);
        chk(rv, 32'h0, "unmapped");
        rd(REG_VERIFY);
        chk(rv, 32'h0, "verify idle");
        rd(REG_COUNT);
        chk(rv, 32'h5, "count");
        chk(q.size(), 32'h0, "missing fires");
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: tb/fscl_ctrl_props.sv
// assertion checker on the decoder side of the command link controller
`timescale 1ns/1ps
`default_nettype none
module fscl_ctrl_props
    import fscl_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = CMD_INTERVAL_CYC,
    parameter int unsigned STAGES       = NUM_STAGES
) (
    input wire logic              i_sys_clk,
    input wire logic              i_sys_rst,
    input wire logic [7:0]        o_cmd_code,
    input wire logic [STAGES-1:0] o_stage_sel_a,
    input wire logic [STAGES-1:0] o_stage_sel_b,
    input wire logic              o_read_a,
    input wire logic              o_read_b,
    input wire logic              o_freset_a,
    input wire logic              o_freset_b,
    input wire logic [7:0]        i_verify
);
    logic [31:0] cnt_r;
    logic        sel_d_r;
    logic        read_d_r;
    logic        retry_r;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    always_ff @(posedge i_sys_clk) begin
        sel_d_r <= |o_stage_sel_a;
        read_d_r <= o_read_a;
    end
    always_ff @(posedge i_sys_clk) begin
        cnt_r <= (i_sys_rst || !o_freset_a) ? 32'h0 : cnt_r + 32'h1;
    end
    // set by a reset that follows a load, until that read ends
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || (read_d_r && !o_read_a)) begin
            retry_r <= 1'h0;
        end else if (o_freset_a && sel_d_r) begin
            retry_r <= 1'h1;
        end
    end
    sequence s_loaded;
        |o_stage_sel_a && !o_read_a && !o_freset_a;
    endsequence
    property p_pair;
        o_stage_sel_a == o_stage_sel_b && o_read_a == o_read_b && o_freset_a == o_freset_b;
    endproperty
    a_pair: assert property (p_pair) else $error("line pair differs");
    property p_one_sel;
        $onehot0(o_stage_sel_a);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("several selects");
    property p_one_pass;
        !(o_read_a && o_freset_a);
    endproperty
    a_one_pass: assert property (p_one_pass) else $error("read with reset");
    property p_hold;
        o_read_a |-> $stable(o_cmd_code) && $stable(o_stage_sel_a);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved in read");
    property p_frst_len;
        $fell(o_freset_a) |-> cnt_r == STEP_CYC;
    endproperty
    a_frst_len: assert property (p_frst_len) else $error("reset length");
    property p_agree;
        s_loaded ##1 ($rose(o_read_a) && !retry_r) |-> $past(i_verify) == ~o_cmd_code;
    endproperty
    a_agree: assert property (p_agree) else $error("read on bad verify");
    property p_disagree;
        s_loaded ##1 $rose(o_freset_a) |-> $past(i_verify) != ~$past(o_cmd_code);
    endproperty
    a_disagree: assert property (p_disagree) else $error("reset on good verify");
    property p_clear;
        $rose(|o_stage_sel_a) && !retry_r |-> $past(i_verify) == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("load on busy lines");
endmodule
bind fscl_ctrl fscl_ctrl_props #(.INTERVAL_CYC(INTERVAL_CYC), .STAGES(STAGES)) props_u (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .o_cmd_code(o_cmd_code),
    .o_stage_sel_a(o_stage_sel_a), .o_stage_sel_b(o_stage_sel_b), .o_read_a(o_read_a),
    .o_read_b(o_read_b), .o_freset_a(o_freset_a), .o_freset_b(o_freset_b),
    .i_verify(i_verify));
`default_nettype wire

// file: tb/fscl_dec_model.sv
// behavioural stage decoder on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module fscl_dec_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_code,
    input  wire logic       i_sel_a,
    input  wire logic       i_sel_b,
    input  wire logic       i_rd_a,
    input  wire logic       i_rd_b,
    input  wire logic       i_fr_a,
    input  wire logic       i_fr_b,
    input  wire logic       i_stuck,
    input  wire logic       i_bad,
    output logic      [7:0] o_verify,
    output logic            o_fire,
    output logic      [6:0] o_chan,
    output logic      [2:0] o_telem
);
    logic [7:0] code_r;
    logic [7:0] t;
    logic       held_r;
    logic       rd;
    logic       rd_r;
    assign rd = i_rd_a | i_rd_b;
    assign t = code_r[7] ? ~code_r : code_r;
    assign o_chan = t[6:0];
    // local status: latched, read seen, channel fired
    assign o_telem = {held_r, rd, o_fire};
    // bad flips one verify line while latched
    assign o_verify = held_r ? ~code_r ^ {7'h0, i_bad} : 8'h00;
    always @(posedge i_clk) begin
        rd_r <= rd;
        o_fire <= rd && !rd_r && held_r && t < 8'h70;
        if (i_rst || i_fr_a || i_fr_b || (rd_r && !rd)) begin
            held_r <= 1'h0;
            code_r <= 8'h00;
        end else if (i_stuck || i_sel_a || i_sel_b) begin
            held_r <= 1'h1;
            code_r <= i_stuck ? 8'h5a : i_code;
        end
    end
endmodule
`default_nettype wire
